// ===== asp_serial_port.sv
// Summary of operation
// (RULE1) Transmit pin idles high in both formats, floats while transmitter is off.
// (RULE2) Receiver sees a high serial input as an idle line.
// (RULE3) Serial input ignored completely while receiver is off.
// (RULE4) Reserved locations and bits ignore writes and read back zero.
// (RULE5) Alternate map clear: offsets 0..2 are divisor high, divisor low, line control.
// (RULE6) Alternate map set: offsets 0..2 are alternate registers; 3..7 unchanged.
// (RULE7) Alternate map bit resets to zero.
// (RULE8) Rate is clock over divisor, or clock over twice divisor[15:1] in infrared.
// (RULE9) Baud generator stopped after reset until transmitter or receiver first enabled.
// (RULE10) Generator held off when divisor[15:4] or, infrared, divisor[15:5] is zero.
// (RULE11) New divisor loaded only at start of next sample clock period.
// (RULE12) Software should write both divisor bytes together in one access; here each byte has its own word offset and needs its own write.
// (RULE13) Same behaviour in normal, special and emulation chip modes.
// (RULE14) Down-counter reloaded from divisor; each underflow gives one sample tick.
`include "asp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port (
	// Clock and reset
	input  wire logic               mclk_i,
	input  wire logic               rst_b_i,
	// Avalon-MM slave
	input  wire asp_pkg::asp_req_t  avs_req_i,
	output var  logic [31:0]        avs_readdata_o,
	output var  logic               avs_waitrequest_o,
	// Serial pins
	input  wire logic               rxd_i,
	output var  logic               txd_o,
	output var  logic               txd_oe_o,
	// Sample tick and interrupt
	output var  logic               rx_sample_clock_o,
	output var  logic               irq_o
);
	import asp_pkg::*;

	// Registers
	logic [7:0]  bd_high_q, bd_low_q, line_ctrl_q, main_ctrl_q, aux_q;
	logic [7:0]  alt_stat_q, alt_int_q, alt_ctrl_q, data_high_q, data_low_q;
	logic [15:0] div_act_q, cnt_q;
	logic [`ASP_IRQ_BITS-1:0] irq_stat_q, irq_mask_q;
	logic        started_q, ack_q, rx_m_q, rx_s_q, rx_prev_q;
	asp_gen_t    gen_q;

	// Bus decode; a one-cycle wait gives registered read data
	wire         acc      = (avs_req_i.read | avs_req_i.write) & ~ack_q;
	// Writes commit on the answer edge, while the master still holds the request
	wire         wr       = avs_req_i.write & ack_q;
	wire  [3:0]  idx      = avs_req_i.address[5:2];
	wire         alt_map  = aux_q[`ASP_BIT_ALT_MAP];
	wire  [7:0]  wb       = avs_req_i.writedata[7:0];
	wire         ir_on    = alt_ctrl_q[`ASP_BIT_INFRARED];
	wire         tx_on    = main_ctrl_q[`ASP_BIT_TX_ON];
	wire         rx_on    = main_ctrl_q[`ASP_BIT_RX_ON];
	wire         rx_line  = rx_on ? rx_s_q : 1'b1; // Off receiver reads idle [RULE3]

	function automatic logic hit(input logic [3:0] i, input logic [3:0] k);
		hit = (i == k) & wr;
	endfunction

	// Shared offsets switch with the alternate map bit
	wire w_bdh  = hit(idx, {1'b0, `ASP_IDX_BD_HIGH})   & ~alt_map;   // [RULE5]
	wire w_bdl  = hit(idx, {1'b0, `ASP_IDX_BD_LOW})    & ~alt_map;   // [RULE5]
	wire w_lc   = hit(idx, {1'b0, `ASP_IDX_LINE_CTRL}) & ~alt_map;   // [RULE5]
	wire w_ast  = hit(idx, {1'b0, `ASP_IDX_BD_HIGH})   & alt_map;    // [RULE6]
	wire w_aint = hit(idx, {1'b0, `ASP_IDX_BD_LOW})    & alt_map;    // [RULE6]
	wire w_actl = hit(idx, {1'b0, `ASP_IDX_LINE_CTRL}) & alt_map;    // [RULE6]
	wire w_mc   = hit(idx, {1'b0, `ASP_IDX_MAIN_CTRL});
	wire w_aux  = hit(idx, {1'b0, `ASP_IDX_AUX_STAT});
	wire w_dh   = hit(idx, {1'b0, `ASP_IDX_DATA_HIGH});
	wire w_dl   = hit(idx, {1'b0, `ASP_IDX_DATA_LOW});
	wire w_is   = hit(idx, `ASP_IDX_IRQ_STAT);
	wire w_im   = hit(idx, `ASP_IDX_IRQ_MASK);

	// Read mux; reserved bits and unmapped words read zero
	// Data is captured on the request edge, so it stands during the answer cycle
	// Software sees only the low byte; the rest of the word is always zero
	logic [7:0] rd_byte;
	always_comb begin
		case (idx)
			4'h0:    rd_byte = alt_map ? {alt_stat_q[7], 4'h0, alt_stat_q[2:0]} : bd_high_q;
			4'h1:    rd_byte = alt_map ? {alt_int_q[7], 5'h00, alt_int_q[1:0]} : bd_low_q;
			4'h2:    rd_byte = alt_map ? {alt_ctrl_q[7:5], 2'h0, alt_ctrl_q[2:0]} : line_ctrl_q;
			4'h3:    rd_byte = main_ctrl_q;
			4'h4:    rd_byte = {5'h00, rx_line, 2'h0}; // High line reads idle [RULE2]
			4'h5:    rd_byte = {aux_q[7], 2'h0, aux_q[4:0]};
			4'h6:    rd_byte = {data_high_q[7:6], 6'h00};
			4'h7:    rd_byte = data_low_q;
			4'h8:    rd_byte = {5'h00, irq_stat_q};
			4'h9:    rd_byte = {5'h00, irq_mask_q};
			default: rd_byte = 8'h00; // [RULE4]
		endcase
	end

	// Register writes; reserved bits are masked off
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bd_high_q   <= `ASP_RST_BD_HIGH;
			bd_low_q    <= `ASP_RST_BD_LOW;
			line_ctrl_q <= `ASP_RST_BYTE;
			main_ctrl_q <= `ASP_RST_BYTE;
			aux_q       <= `ASP_RST_BYTE; // [RULE7]
			alt_stat_q  <= `ASP_RST_BYTE;
			alt_int_q   <= `ASP_RST_BYTE;
			alt_ctrl_q  <= `ASP_RST_BYTE;
			data_high_q <= `ASP_RST_BYTE;
			data_low_q  <= `ASP_RST_BYTE;
			irq_mask_q  <= '0;
		end else begin
			if (w_bdh)  bd_high_q   <= wb;
			if (w_bdl)  bd_low_q    <= wb;
			if (w_lc)   line_ctrl_q <= wb;
			if (w_ast)  alt_stat_q  <= alt_stat_q & ~(wb & 8'h83); // W1C flags [RULE4]
			if (w_aint) alt_int_q   <= wb & 8'h83; // [RULE4]
			if (w_actl) alt_ctrl_q  <= wb & 8'hE7; // [RULE4]
			if (w_mc)   main_ctrl_q <= wb;
			if (w_aux)  aux_q       <= wb & 8'h9F; // [RULE4]
			if (w_dh)   data_high_q <= wb & 8'h40; // [RULE4]
			if (w_dl)   data_low_q  <= wb;
			if (w_im)   irq_mask_q  <= avs_req_i.writedata[`ASP_IRQ_BITS-1:0];
		end
	end

	// Bus answer: waitrequest low one cycle after request is seen
	// Fixed latency keeps the slave simple; back to back requests cost two cycles
	// The ack flop also blocks a second capture while the request still stands
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_q          <= 1'b0;
			avs_readdata_o <= 32'h0000_0000;
		end else begin
			ack_q          <= acc;
			avs_readdata_o <= acc ? {24'h00_0000, rd_byte} : avs_readdata_o;
		end
	end
	assign avs_waitrequest_o = ~ack_q;

	// Input synchroniser; first stage feeds only the second
	// Edge detector resets to the idle level so reset gives no false edge
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_m_q    <= 1'b1;
			rx_s_q    <= 1'b1;
			rx_prev_q <= 1'b1;
		end else begin
			rx_m_q    <= rxd_i;
			rx_s_q    <= rx_m_q;
			rx_prev_q <= rx_line; // Off receiver reads idle [RULE3] [RULE2]
		end
	end

	// Generator enable and rate; same in every chip mode [RULE13]
	// A too small divisor stops ticks at once, even mid period
	// Infrared clears divisor bit zero, giving twice the upper fifteen bits
	wire        div_ok   = ir_on ? ({bd_high_q, bd_low_q[7:5]} != 11'h000)
	                             : ({bd_high_q, bd_low_q[7:4]} != 12'h000); // [RULE10]
	wire [15:0] div_new  = ir_on ? {bd_high_q, bd_low_q[7:1], 1'b0}
	                             : {bd_high_q, bd_low_q}; // [RULE8]
	wire        under    = (cnt_q == 16'h0001);
	wire        running  = (gen_q == ASP_ST_RUN);
	wire        tick     = running & under & div_ok; // [RULE10]
	wire        go       = started_q & div_ok;
	wire        rx_fall  = rx_prev_q & ~rx_line;

	// Down-counter reloads at each sample period start [RULE14] [RULE11]
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			started_q <= 1'b0;
			gen_q     <= ASP_ST_STOPPED;
			div_act_q <= 16'h0000;
			cnt_q     <= 16'h0000;
		end else begin
			started_q <= started_q | tx_on | rx_on; // [RULE9]
			case (gen_q)
				ASP_ST_STOPPED: if (go) begin
					gen_q     <= ASP_ST_RUN;
					div_act_q <= div_new;
					cnt_q     <= div_new;
				end
				ASP_ST_RUN: if (!div_ok) begin
					gen_q <= ASP_ST_HELD; // [RULE10]
				end else if (under) begin
					div_act_q <= div_new; // [RULE11]
					cnt_q     <= div_new;
				end else begin
					cnt_q <= cnt_q - 16'h0001;
				end
				ASP_ST_HELD: if (div_ok) gen_q <= ASP_ST_STOPPED;
				default: gen_q <= ASP_ST_STOPPED;
			endcase
		end
	end

	// Sticky events, write one to clear; set beats clear
	// Interrupt is registered from the next status so it never lags a set
	wire [`ASP_IRQ_BITS-1:0] ev  = {tick & (div_new != div_act_q), tick, rx_fall};
	wire [`ASP_IRQ_BITS-1:0] clr = w_is ? avs_req_i.writedata[`ASP_IRQ_BITS-1:0] : '0;
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_stat_q <= '0;
			irq_o      <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~clr) | ev;
			irq_o      <= |(((irq_stat_q & ~clr) | ev) & irq_mask_q);
		end
	end

	// Pins: idle high, floated while transmitter off; pol swaps level
	// No transmitter here, so the pin only ever shows its idle level
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			txd_o             <= 1'b1;
			txd_oe_o          <= 1'b0;
			rx_sample_clock_o <= 1'b0;
		end else begin
			txd_o             <= ~aux_q[`ASP_BIT_TXPOL]; // [RULE1]
			txd_oe_o          <= tx_on; // [RULE1]
			rx_sample_clock_o <= tick; // [RULE14]
		end
	end

	// Assertions
	property p_rst_map; // [RULE7]
		@(posedge mclk_i) $rose(rst_b_i) |-> !aux_q[`ASP_BIT_ALT_MAP];
	endproperty
	a_rst_map: assert property (p_rst_map) else $error("alt map not zero after reset");
	property p_tx_float; // [RULE1]
		@(posedge mclk_i) disable iff (!rst_b_i) !tx_on |=> !txd_oe_o;
	endproperty
	a_tx_float: assert property (p_tx_float) else $error("tx driven while off");
	property p_no_start; // [RULE9]
		@(posedge mclk_i) disable iff (!rst_b_i) !started_q |-> gen_q == ASP_ST_STOPPED;
	endproperty
	a_no_start: assert property (p_no_start) else $error("generator ran before enable");
	property p_held; // [RULE10]
		@(posedge mclk_i) disable iff (!rst_b_i) !div_ok |=> !tick;
	endproperty
	a_held: assert property (p_held) else $error("tick with small divisor");
	property p_reload; // [RULE11]
		@(posedge mclk_i) disable iff (!rst_b_i) tick |=> cnt_q == $past(div_new);
	endproperty
	a_reload: assert property (p_reload) else $error("reload missed");
	property p_stable_div; // [RULE11]
		@(posedge mclk_i) disable iff (!rst_b_i) (running && !under) |=> $stable(div_act_q);
	endproperty
	a_stable_div: assert property (p_stable_div) else $error("divisor changed mid period");
	property p_rx_ign; // [RULE3]
		@(posedge mclk_i) disable iff (!rst_b_i) !rx_on |=> !irq_stat_q[0] || $past(irq_stat_q[0]);
	endproperty
	a_rx_ign: assert property (p_rx_ign) else $error("rx event while receiver off");
	property p_res_zero; // [RULE4]
		@(posedge mclk_i) disable iff (!rst_b_i) (acc && idx > 4'h9) |=> avs_readdata_o == 0;
	endproperty
	a_res_zero: assert property (p_res_zero) else $error("reserved read not zero");
	property p_ack; // Bus answer after one wait cycle
		@(posedge mclk_i) disable iff (!rst_b_i) acc |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer timing wrong");
	c_tick: cover property (@(posedge mclk_i) disable iff (!rst_b_i) tick);
	c_alt: cover property (@(posedge mclk_i) disable iff (!rst_b_i) w_actl);
	c_irq: cover property (@(posedge mclk_i) disable iff (!rst_b_i) $rose(irq_o));
	c_held: cover property (@(posedge mclk_i) disable iff (!rst_b_i) gen_q == ASP_ST_HELD);
	c_rx: cover property (@(posedge mclk_i) disable iff (!rst_b_i) rx_fall);

	// Transmitter on drives the pin
	property p_oe_on; // [RULE1]
		@(posedge mclk_i) disable iff (!rst_b_i) tx_on |=> txd_oe_o;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("tx not driven while on");

	// Normal polarity idles high
	property p_tx_idle; // [RULE1]
		@(posedge mclk_i) disable iff (!rst_b_i) !aux_q[`ASP_BIT_TXPOL] |=> txd_o;
	endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("tx not idle high");

	// Generator stopped out of reset
	property p_rst_gen; // [RULE9]
		@(posedge mclk_i) $rose(rst_b_i) |-> gen_q == ASP_ST_STOPPED && !started_q;
	endproperty
	a_rst_gen: assert property (p_rst_gen) else $error("generator not stopped at reset");

	// Held generator returns through stopped
	property p_held_stop; // [RULE10]
		@(posedge mclk_i) disable iff (!rst_b_i) (gen_q == ASP_ST_HELD && div_ok) |=> gen_q == ASP_ST_STOPPED;
	endproperty
	a_held_stop: assert property (p_held_stop) else $error("held generator stuck");

	// Counter steps down by one between underflows
	property p_count_down; // [RULE14]
		@(posedge mclk_i) disable iff (!rst_b_i) (running && !under && div_ok) |=> cnt_q == $past(cnt_q) - 16'h0001;
	endproperty
	a_count_down: assert property (p_count_down) else $error("counter did not step");

	// Every underflow reaches the tick output
	property p_tick_out; // [RULE14]
		@(posedge mclk_i) disable iff (!rst_b_i) tick |=> rx_sample_clock_o;
	endproperty
	a_tick_out: assert property (p_tick_out) else $error("tick lost");

	// Tick is a single cycle pulse
	property p_tick_pulse; // [RULE14]
		@(posedge mclk_i) disable iff (!rst_b_i) rx_sample_clock_o |=> !rx_sample_clock_o;
	endproperty
	a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");

	// Rate taken from the divisor at the reload
	property p_rate; // [RULE8]
		@(posedge mclk_i) disable iff (!rst_b_i) tick |=> div_act_q == $past(div_new);
	endproperty
	a_rate: assert property (p_rate) else $error("active divisor wrong");

	// Off receiver reads an idle line
	property p_rx_off_stat; // [RULE3]
		@(posedge mclk_i) disable iff (!rst_b_i) (!rx_on && acc && idx == 4'h4) |=> avs_readdata_o[2];
	endproperty
	a_rx_off_stat: assert property (p_rx_off_stat) else $error("off receiver not idle");

	// High input reads as idle
	property p_idle_stat; // [RULE2]
		@(posedge mclk_i) disable iff (!rst_b_i) (rx_on && rx_s_q && acc && idx == 4'h4) |=> avs_readdata_o[2];
	endproperty
	a_idle_stat: assert property (p_idle_stat) else $error("high line not idle");

	// Unused upper bits of the word read zero
	property p_upper_zero; // [RULE4]
		@(posedge mclk_i) disable iff (!rst_b_i) avs_readdata_o[31:8] == 24'h00_0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");

	// Reserved alternate status bits read zero
	property p_alt_res; // [RULE4]
		@(posedge mclk_i) disable iff (!rst_b_i) (acc && alt_map && idx == 4'h0) |=> avs_readdata_o[6:3] == 4'h0;
	endproperty
	a_alt_res: assert property (p_alt_res) else $error("reserved status bits set");

	// Clear map shows the divisor low byte
	property p_map_low; // [RULE5]
		@(posedge mclk_i) disable iff (!rst_b_i) (acc && !alt_map && idx == 4'h1) |=> avs_readdata_o[7:0] == $past(bd_low_q);
	endproperty
	a_map_low: assert property (p_map_low) else $error("divisor low not mapped");

	// Set map hides the divisor from writes
	property p_map_alt; // [RULE6]
		@(posedge mclk_i) disable iff (!rst_b_i) (wr && alt_map && idx == 4'h1) |=> $stable(bd_low_q);
	endproperty
	a_map_alt: assert property (p_map_alt) else $error("divisor written in alternate map");

	// Event wins over a clear in the same cycle
	property p_set_wins;
		@(posedge mclk_i) disable iff (!rst_b_i) tick |=> irq_stat_q[1];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("tick event lost");

	// Write one clears a flag
	property p_w1c;
		@(posedge mclk_i) disable iff (!rst_b_i) (w_is && avs_req_i.writedata[1] && !tick) |=> !irq_stat_q[1];
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag not cleared");

	// Interrupt follows unmasked status
	property p_irq_level;
		@(posedge mclk_i) disable iff (!rst_b_i) !w_im |=> irq_o == |(irq_stat_q & irq_mask_q);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

	// Writes only commit in the answer cycle
	property p_write_wait;
		@(posedge mclk_i) disable iff (!rst_b_i) wr |-> !avs_waitrequest_o;
	endproperty
	a_write_wait: assert property (p_write_wait) else $error("write before answer");
endmodule
`default_nettype wire

// ===== asp_consts.svh
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH
// Register offsets (word indices of 32-bit words; byte address is index times four)
`define ASP_IDX_BD_HIGH     3'h0
`define ASP_IDX_BD_LOW      3'h1
`define ASP_IDX_LINE_CTRL   3'h2
`define ASP_IDX_MAIN_CTRL   3'h3
`define ASP_IDX_MAIN_STAT   3'h4
`define ASP_IDX_AUX_STAT    3'h5
`define ASP_IDX_DATA_HIGH   3'h6
`define ASP_IDX_DATA_LOW    3'h7
`define ASP_IDX_IRQ_STAT    4'h8
`define ASP_IDX_IRQ_MASK    4'h9
// Field positions
`define ASP_BIT_ALT_MAP     7
`define ASP_BIT_INFRARED    7
`define ASP_BIT_TX_ON       3
`define ASP_BIT_RX_ON       2
`define ASP_BIT_TXPOL       4
`define ASP_BIT_RXPOL       3
// Reset values
`define ASP_RST_BD_HIGH     8'h00
`define ASP_RST_BD_LOW      8'h04
`define ASP_RST_BYTE        8'h00
// Events: bit0 rx falling edge, bit1 tick, bit2 reload with a changed divisor
`define ASP_IRQ_BITS        3
`define ASP_OVERSAMPLE      4'hF
`endif

// ===== asp_pkg.sv
package asp_pkg;
	typedef struct packed {
		logic        read;
		logic        write;
		logic [5:0]  address;
		logic [31:0] writedata;
	} asp_req_t;
	typedef struct packed {
		logic        tx_data;
		logic        tx_oe;
	} asp_pin_t;
	typedef enum logic [1:0] {
		ASP_ST_STOPPED = 2'b00,
		ASP_ST_RUN     = 2'b01,
		ASP_ST_HELD    = 2'b10
	} asp_gen_t;
endpackage

// ===== asp_serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Serial peer: one 8N1 frame per send request, 32 clocks per bit
module asp_serial_peer #(
	parameter int BIT_CYC = 32
) (
	input  wire logic       mclk_i,
	input  wire logic       send_i,
	input  wire logic [7:0] byte_i,
	output var  logic       rxd_o
);
	logic [9:0] frame_q = 10'h3FF;
	int         left_q  = 0;
	// Frame shifter; a send during a frame is dropped, not queued
	always @(posedge mclk_i) begin
		if (send_i && left_q == 0) begin
			frame_q <= {1'b1, byte_i, 1'b0};
			left_q  <= 10 * BIT_CYC;
		end else if (left_q != 0) begin
			left_q <= left_q - 1;
		end
	end
	// Start bit first, then LSB first; mark level between frames
	assign rxd_o = (left_q == 0) ? 1'b1 : frame_q[9 - (left_q - 1) / BIT_CYC];
endmodule
`default_nettype wire

// ===== test_async_serial_port_regs_baud.sv
`timescale 1ns/1ps
`default_nettype none
module test_async_serial_port_regs_baud;
	import asp_pkg::*;
	logic        mclk_i  = 1'b0;
	logic        rst_b_i = 1'b0;
	asp_req_t    req     = '0;
	logic        send    = 1'b0;
	logic [7:0]  sbyte   = 8'h55;
	logic [31:0] seed    = 32'h0000_0046;
	logic [31:0] rdata;
	logic        wreq, rxd, txd, txd_oe, tick, irq;
	logic [31:0] exp_q[$], msk_q[$];
	logic [15:0] d0, d1, d2;
	logic [7:0]  lc;
	int          bad_count = 0, n_compared = 0, c;
	asp_serial_port uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .avs_req_i(req),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .rxd_i(rxd), .txd_o(txd),
		.txd_oe_o(txd_oe), .rx_sample_clock_o(tick), .irq_o(irq));
	asp_serial_peer peer (.mclk_i(mclk_i), .send_i(send), .byte_i(sbyte), .rxd_o(rxd));
	// 50 MHz clock
	initial begin
		forever #10 mclk_i = ~mclk_i;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Request held until waitrequest is sampled low, one idle edge after
	task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		req <= '{read: !wr, write: wr, address: {idx, 2'b00}, writedata: {24'h00_0000, d}};
		do begin
			@(posedge mclk_i);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		if (wreq !== 1'b0) begin
			bad_count++;
			stop_test();
		end
		req <= '0;
		@(posedge mclk_i);
	endtask
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask
	task automatic rd(input logic [3:0] idx, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFF_FFFF);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus(1'b0, idx, 8'h00);
	endtask
	// Cycles until the next sample tick, capped at lim
	task automatic gap(input int lim);
		c = 0;
		do begin
			@(posedge mclk_i);
			c++;
		end while (tick !== 1'b1 && c < lim);
	endtask
	task automatic send_frame();
		send <= 1'b1;
		@(posedge mclk_i);
		send <= 1'b0;
		repeat (400) @(posedge mclk_i);
	endtask
	// Watcher: oldest note judged at the edge that completes the read
	always @(posedge mclk_i) begin
		if (req.read === 1'b1 && wreq === 1'b0 && exp_q.size() > 0) begin
			chk("readdata", exp_q[0], rdata & msk_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
	end
	initial begin
		repeat (5) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		@(posedge mclk_i);
		chk("txd", 1'b1, txd);
		chk("txd_oe", 1'b0, txd_oe);
		rd(4'h0, 32'h0000_0000);
		rd(4'h1, 32'h0000_0004);
		rd(4'h5, 32'h0000_0000, 32'h0000_0080);
		wr(4'hA, 8'hFF);
		rd(4'hA, 32'h0000_0000);
		$display("test reset done");
		lc = 8'(xs());
		wr(4'h2, lc);
		rd(4'h2, {24'h00_0000, lc});
		wr(4'h5, 8'hE0);
		rd(4'h5, 32'h0000_0080);
		wr(4'h1, 8'hFF);
		rd(4'h1, 32'h0000_0083);
		wr(4'h2, 8'h1F);
		rd(4'h2, 32'h0000_0007);
		wr(4'h3, 8'h20);
		rd(4'h3, 32'h0000_0020);
		wr(4'h5, 8'h00);
		rd(4'h2, {24'h00_0000, lc});
		rd(4'h1, 32'h0000_0004);
		$display("test map done");
		d0 = 16'(16 + xs() % 32);
		d1 = d0 + 16'h0008;
		wr(4'h1, d0[7:0]);
		gap(100);
		chk("stopped", 100, c);
		wr(4'h3, 8'h08);
		gap(2000);
		gap(2000);
		chk("txd_oe on", 1'b1, txd_oe);
		gap(2000);
		chk("period", d0, c);
		wr(4'h1, d1[7:0]);
		gap(2000);
		chk("old period", d0 - 3, c);
		gap(2000);
		chk("new period", d1, c);
		$display("test rate done");
		d2 = 16'(33 + 2 * (xs() % 15));
		wr(4'h5, 8'h80);
		wr(4'h2, 8'h80);
		wr(4'h5, 8'h00);
		wr(4'h1, d2[7:0]);
		repeat (3) gap(2000);
		chk("ir period", d2 - 1, c);
		chk("ir idle", 1'b1, txd);
		wr(4'h1, 8'h1F);
		gap(2000);
		gap(200);
		chk("ir held", 200, c);
		wr(4'h5, 8'h80);
		wr(4'h2, 8'h00);
		wr(4'h5, 8'h00);
		$display("test infrared done");
		wr(4'h9, 8'h00);
		wr(4'h8, 8'h07);
		gap(2000);
		repeat (3) @(posedge mclk_i);
		chk("irq masked", 1'b0, irq);
		wr(4'h9, 8'h02);
		gap(2000);
		repeat (3) @(posedge mclk_i);
		chk("irq set", 1'b1, irq);
		wr(4'h1, 8'h0F);
		gap(200);
		gap(200);
		chk("held", 200, c);
		wr(4'h8, 8'h07);
		repeat (3) @(posedge mclk_i);
		chk("irq clear", 1'b0, irq);
		rd(4'h8, 32'h0000_0000, 32'h0000_0002);
		$display("test irq done");
		send_frame();
		rd(4'h8, 32'h0000_0000, 32'h0000_0001);
		wr(4'h3, 8'h0C);
		rd(4'h4, 32'h0000_0004, 32'h0000_0004);
		send_frame();
		rd(4'h8, 32'h0000_0001, 32'h0000_0001);
		$display("test receive done");
		repeat (4) @(posedge mclk_i);
		chk("pending reads", 0, exp_q.size());
		stop_test();
	end
endmodule
`default_nettype wire
